// [src/liu_pkg.sv]
// What this block does
// [RQ1] receiver powered on when its enable bit is one
// [RQ2] five-bit equalizer code drives pulse shape and monitoring
// [RQ3] termination select bits: zero external, one internal
// [RQ4] jitter path: 00 off, 01 transmit, 1x receive
// [RQ5] E1: bandwidth bit picks 1.5 Hz/64 or 10 Hz
// [RQ6] T1: bandwidth fixed 3 Hz, depth bit still applies
// [RQ7] transmitter enable; off tri-states both driver outputs
// [RQ8] loop-back field: 0xx none, then dual/analog/remote/digital
// [RQ9] loop-code mode: off, up, down, automatic
// [RQ10] single rail: one selects AMI, zero HDB3/B8ZS
// [RQ11] eight identical channel sets at channel times sixteen
// [RQ12] impedance code selects 100, 110, 75, 120 ohm
// [RQ13] manual detect flag follows pattern persisting five seconds
// [RQ14] every detect flag change requests interrupt when enabled
// [RQ15] auto: loop-up persists, set flag, enter remote loop
// [RQ16] auto: loop-down persists, leave remote loop, clear flag
package liu_pkg;
   localparam int unsigned NUM_CHANNELS     = 8;
   localparam int unsigned CLK_HZ           = 50_000_000;
   localparam int unsigned LOOP_PERSIST_MS  = 5000;
   localparam int unsigned LOOP_PERSIST_CYC =
      CLK_HZ / 1000 * LOOP_PERSIST_MS;

   localparam logic [1:0] REG_RX_EQ    = 2'h0;
   localparam logic [1:0] REG_TERM_JA  = 2'h1;
   localparam logic [1:0] REG_TX_LOOP  = 2'h2;
   localparam logic [1:0] REG_LC_CODE  = 2'h3;
   localparam logic [7:0] REG_RESET    = 8'h00;

   // register 0
   localparam int unsigned RX_ON_BIT    = 5;
   localparam int unsigned EQ_MSB       = 4;
   // register 1
   localparam int unsigned RX_TERM_BIT  = 7;
   localparam int unsigned TX_TERM_BIT  = 6;
   localparam int unsigned IMP_MSB      = 5;
   localparam int unsigned IMP_LSB      = 4;
   localparam int unsigned JA_MSB       = 3;
   localparam int unsigned JA_LSB       = 2;
   localparam int unsigned JA_BW_BIT    = 1;
   localparam int unsigned FIFO_BIT     = 0;
   // register 2
   localparam int unsigned PRBS_INV_BIT = 7;
   localparam int unsigned TEST_MSB     = 6;
   localparam int unsigned TEST_LSB     = 4;
   localparam int unsigned TX_ON_BIT    = 3;
   localparam int unsigned LOOP_MSB     = 2;
   // register 3
   localparam int unsigned LC_MSB       = 7;
   localparam int unsigned LC_LSB       = 6;
   localparam int unsigned AMI_BIT      = 5;

   localparam logic [1:0] LC_OFF  = 2'h0;
   localparam logic [1:0] LC_UP   = 2'h1;
   localparam logic [1:0] LC_DOWN = 2'h2;
   localparam logic [1:0] LC_AUTO = 2'h3;

   localparam logic [2:0] LB_NONE    = 3'h0;
   localparam logic [2:0] LB_DUAL    = 3'h1;
   localparam logic [2:0] LB_ANALOG  = 3'h2;
   localparam logic [2:0] LB_REMOTE  = 3'h3;
   localparam logic [2:0] LB_DIGITAL = 3'h4;

   localparam logic [7:0] OHM_100 = 8'h64;
   localparam logic [7:0] OHM_110 = 8'h6e;
   localparam logic [7:0] OHM_75  = 8'h4b;
   localparam logic [7:0] OHM_120 = 8'h78;

   // jitter bandwidth in tenths of a hertz
   localparam logic [7:0] JA_BW_1P5 = 8'h0f;
   localparam logic [7:0] JA_BW_10  = 8'h64;
   localparam logic [7:0] JA_BW_3   = 8'h1e;
endpackage : liu_pkg

// [src/loop_code_detect.sv]
`timescale 1ns/1ps
module loop_code_detect #(
   parameter int unsigned PERSIST_CYCLES = liu_pkg::LOOP_PERSIST_CYC
) (
   input  wire logic       ref_clk,     // clock
   input  wire logic       arst_n,      // async reset
   input  wire logic [1:0] mode,        // detection mode field
   input  wire logic       up_seen,     // loop-up pattern present
   input  wire logic       down_seen,   // loop-down pattern present
   input  wire logic       irq_en,      // change request enable
   output logic            detected,    // detected flag
   output logic            remote_auto, // auto remote loop-back
   output logic            change_req   // one-cycle change request
);
   import liu_pkg::*;
   localparam int unsigned CW = $clog2(PERSIST_CYCLES + 1);
   localparam logic [CW-1:0] CNT_TOP = CW'(PERSIST_CYCLES);

   typedef enum logic {ST_WAIT_UP, ST_LOOPED} lc_state_e;

   lc_state_e     state_ff;
   lc_state_e     nxt_state;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic [1:0]    mode_ff;
   logic          flag_ff;
   logic          nxt_flag;
   logic          req_ff;

   wire auto_mode = (mode == LC_AUTO);
   wire mode_chg  = (mode != mode_ff);
   wire looped    = (state_ff == ST_LOOPED);
   wire watch     = (mode == LC_UP)   ? up_seen :
                    (mode == LC_DOWN) ? down_seen :
                    auto_mode ? (looped ? down_seen : up_seen) : 1'b0;
   // pattern must last longer than the persistence time
   wire persisted = watch && (cnt_ff == CNT_TOP);

   always_comb begin
      nxt_state = state_ff;
      if (mode_chg || !auto_mode) begin
         nxt_state = ST_WAIT_UP;
      end else if (persisted) begin
         nxt_state = looped ? ST_WAIT_UP : ST_LOOPED; // [RQ15] [RQ16]
      end
   end

   // counter restarts when the watched pattern swaps, else the old run
   // would count toward the new one
   always_comb begin
      nxt_cnt = cnt_ff;
      if (!watch || mode_chg || (nxt_state != state_ff)) begin
         nxt_cnt = '0;
      end else if (cnt_ff != CNT_TOP) begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   always_comb begin
      nxt_flag = 1'b0;
      if (mode_chg) begin
         nxt_flag = 1'b0;
      end else if (auto_mode) begin
         nxt_flag = (nxt_state == ST_LOOPED); // [RQ15] [RQ16]
      end else if (mode != LC_OFF) begin
         nxt_flag = persisted; // [RQ13]
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_WAIT_UP;
         cnt_ff   <= '0;
         mode_ff  <= LC_OFF;
         flag_ff  <= 1'b0;
         req_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         mode_ff  <= mode;
         flag_ff  <= nxt_flag;
         req_ff   <= irq_en && (nxt_flag != flag_ff); // [RQ14]
      end
   end

   assign detected    = flag_ff;
   assign remote_auto = auto_mode && looped; // [RQ15]
   assign change_req  = req_ff;
endmodule : loop_code_detect

// [src/liu_channel_control_regs.sv]
`timescale 1ns/1ps
module liu_channel_control_regs #(
   parameter int unsigned NCH            = liu_pkg::NUM_CHANNELS,
   parameter int unsigned PERSIST_CYCLES = liu_pkg::LOOP_PERSIST_CYC
) (
   input  wire logic              ref_clk,          // 50 MHz clock
   input  wire logic              arst_n,           // async reset
   input  wire logic              cs_n,             // chip select pin
   input  wire logic              rd_n,             // read strobe pin
   input  wire logic              wr_n,             // write strobe pin
   input  wire logic [7:0]        addr,             // address pins
   input  wire logic [7:0]        data_in,          // data pins in
   output logic      [7:0]        data_out,         // data pins out
   output logic                   data_oe_n,        // low drives data
   output logic                   rdy,              // access complete
   input  wire logic [NCH-1:0]    e1_mode,          // 1 E1, 0 T1
   input  wire logic [NCH-1:0]    single_rail,      // single-rail mode
   input  wire logic [NCH-1:0]    loop_up_seen,     // up code present
   input  wire logic [NCH-1:0]    loop_down_seen,   // down code present
   input  wire logic [NCH-1:0]    loop_irq_en,      // change req enable
   output logic [NCH-1:0]         rx_section_enable,  // receiver on
   output logic [NCH-1:0][4:0]    equalizer_code,     // equalizer code
   output logic [NCH-1:0]         rx_term_internal,   // rx internal term
   output logic [NCH-1:0]         tx_term_internal,   // tx internal term
   output logic [NCH-1:0][7:0]    term_ohms,          // impedance, ohm
   output logic [NCH-1:0]         ja_in_tx,           // jitter in tx
   output logic [NCH-1:0]         ja_in_rx,           // jitter in rx
   output logic [NCH-1:0][7:0]    ja_bw_tenths_hz,    // jitter bandwidth
   output logic [NCH-1:0]         ja_fifo_64,         // 64-bit fifo
   output logic [NCH-1:0]         tx_section_enable,  // transmitter on
   output logic [NCH-1:0]         tx_drive_oe_n,      // low drives line
   output logic [NCH-1:0][2:0]    tx_test_pattern_sel,// test pattern
   output logic [NCH-1:0]         prbs_invert,        // invert prbs
   output logic [NCH-1:0][2:0]    loopback_mode,      // LB_* code
   output logic [NCH-1:0]         ami_coding_select,  // AMI line code
   output logic [NCH-1:0]         hdb3_b8zs_select,   // HDB3/B8ZS code
   output logic [NCH-1:0]         loop_code_detected, // detect flag
   output logic [NCH-1:0]         loop_code_change    // change request
);
   import liu_pkg::*;

   logic [NCH-1:0][3:0][7:0] ctrl_ff;
   logic [2:0]  strb_s1_ff;
   logic [2:0]  strb_s2_ff;
   logic [7:0]  addr_s1_ff;
   logic [7:0]  addr_s2_ff;
   logic [7:0]  din_s1_ff;
   logic [7:0]  din_s2_ff;
   logic [NCH-1:0] pin_s1_ff [4];
   logic [NCH-1:0] pin_s2_ff [4];
   logic        wr_done_ff;
   logic [7:0]  dout_ff;
   logic        rd_act_ff;
   logic [NCH-1:0] remote_auto;

   // strobes and their address/data pass the same two stages, so the
   // host need hold address and data only while its strobe is asserted
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         strb_s1_ff <= 3'h7;
         strb_s2_ff <= 3'h7;
         addr_s1_ff <= 8'h00;
         addr_s2_ff <= 8'h00;
         din_s1_ff  <= 8'h00;
         din_s2_ff  <= 8'h00;
      end else begin
         strb_s1_ff <= {cs_n, rd_n, wr_n};
         strb_s2_ff <= strb_s1_ff;
         addr_s1_ff <= addr;
         addr_s2_ff <= addr_s1_ff;
         din_s1_ff  <= data_in;
         din_s2_ff  <= din_s1_ff;
      end
   end

   // line-mode and rail pins are mostly static straps, but a live change
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) begin
            pin_s1_ff[i] <= '0;
            pin_s2_ff[i] <= '0;
         end
      end else begin
         pin_s1_ff[0] <= e1_mode;
         pin_s1_ff[1] <= single_rail;
         pin_s1_ff[2] <= loop_up_seen;
         pin_s1_ff[3] <= loop_down_seen;
         for (int i = 0; i < 4; i++) begin
            pin_s2_ff[i] <= pin_s1_ff[i];
         end
      end
   end

   wire [NCH-1:0] e1_s    = pin_s2_ff[0];
   wire [NCH-1:0] srail_s = pin_s2_ff[1];
   wire [NCH-1:0] up_s    = pin_s2_ff[2];
   wire [NCH-1:0] down_s  = pin_s2_ff[3];

   wire       wr_act  = !strb_s2_ff[2] && !strb_s2_ff[0];
   wire       rd_act  = !strb_s2_ff[2] && !strb_s2_ff[1] && !wr_act;
   wire [2:0] ch_sel  = addr_s2_ff[6:4]; // [RQ11]
   wire [1:0] reg_sel = addr_s2_ff[1:0];
   // channel n answers at n*16 + 0..3; other locations read as zero
   wire       hit     = !addr_s2_ff[7] && (addr_s2_ff[3:2] == 2'h0) &&
                        (32'(ch_sel) < NCH); // [RQ11]
   // a held strobe writes once; acting on the level would rewrite the
   // register every cycle with whatever the data pins show by then
   wire       wr_pulse = wr_act && !wr_done_ff;
   wire [7:0] rd_word  = hit ? ctrl_ff[ch_sel][reg_sel] : 8'h00;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int c = 0; c < NCH; c++) begin
            for (int r = 0; r < 4; r++) begin
               ctrl_ff[c][r] <= REG_RESET;
            end
         end
      end else if (wr_pulse && hit) begin
         ctrl_ff[ch_sel][reg_sel] <= din_s2_ff; // [RQ11]
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_done_ff <= 1'b0;
         rd_act_ff  <= 1'b0;
         dout_ff    <= 8'h00;
      end else begin
         wr_done_ff <= wr_act;
         rd_act_ff  <= rd_act;
         if (rd_act) begin
            dout_ff <= rd_word;
         end
      end
   end

   // rdy stays up until the strobe release has passed the synchroniser,
   // so a slow host cannot miss the end of its access
   assign data_out  = dout_ff;
   assign data_oe_n = !rd_act_ff;
   assign rdy       = rd_act_ff || wr_done_ff;

   function automatic logic [7:0] imp_ohms(input logic [1:0] code);
      logic [7:0] o;
      o = OHM_100;
      unique case (code)
         2'h0: o = OHM_100;
         2'h1: o = OHM_110;
         2'h2: o = OHM_75;
         2'h3: o = OHM_120;
      endcase
      return o;
   endfunction : imp_ohms

   function automatic logic [2:0] lb_decode(input logic [2:0] f);
      logic [2:0] m;
      m = LB_NONE;
      if (f[2]) begin
         unique case (f[1:0])
            2'h0: m = LB_DUAL;
            2'h1: m = LB_ANALOG;
            2'h2: m = LB_REMOTE;
            2'h3: m = LB_DIGITAL;
         endcase
      end
      return m;
   endfunction : lb_decode

   // T1 ignores the bandwidth bit; in E1 it trades lock time for
   // jitter rejection
   function automatic logic [7:0] ja_bw_code(input logic e1,
                                             input logic narrow);
      logic [7:0] b;
      b = JA_BW_3;
      if (e1) begin
         b = narrow ? JA_BW_1P5 : JA_BW_10;
      end
      return b;
   endfunction : ja_bw_code

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire [7:0] r0 = ctrl_ff[c][REG_RX_EQ];
      wire [7:0] r1 = ctrl_ff[c][REG_TERM_JA];
      wire [7:0] r2 = ctrl_ff[c][REG_TX_LOOP];
      wire [7:0] r3 = ctrl_ff[c][REG_LC_CODE];
      wire       bw = r1[JA_BW_BIT];

      assign rx_section_enable[c] = r0[RX_ON_BIT]; // [RQ1]
      assign equalizer_code[c]    = r0[EQ_MSB:0]; // [RQ2]
      assign rx_term_internal[c]  = r1[RX_TERM_BIT]; // [RQ3]
      assign tx_term_internal[c]  = r1[TX_TERM_BIT]; // [RQ3]
      assign term_ohms[c]         = imp_ohms(r1[IMP_MSB:IMP_LSB]); // [RQ12]
      assign ja_in_tx[c] = (r1[JA_MSB:JA_LSB] == 2'h1); // [RQ4]
      assign ja_in_rx[c] = r1[JA_MSB]; // [RQ4]
      assign ja_bw_tenths_hz[c] = ja_bw_code(e1_s[c], bw); // [RQ5] [RQ6]
      assign ja_fifo_64[c] = (e1_s[c] && bw) || r1[FIFO_BIT]; // [RQ5] [RQ6]
      assign tx_section_enable[c]   = r2[TX_ON_BIT]; // [RQ7]
      assign tx_drive_oe_n[c]       = !r2[TX_ON_BIT]; // [RQ7]
      assign tx_test_pattern_sel[c] = r2[TEST_MSB:TEST_LSB];
      assign prbs_invert[c]         = r2[PRBS_INV_BIT];
      // automatic loop-code handling overrides the programmed field
      assign loopback_mode[c] = remote_auto[c] ? LB_REMOTE : // [RQ15]
                                lb_decode(r2[LOOP_MSB:0]); // [RQ8]
      assign ami_coding_select[c] = srail_s[c] && r3[AMI_BIT]; // [RQ10]
      assign hdb3_b8zs_select[c]  = srail_s[c] && !r3[AMI_BIT]; // [RQ10]

      // a mode change restarts detection, so a stale run never carries over
      loop_code_detect #(
         .PERSIST_CYCLES (PERSIST_CYCLES)
      ) u_lcd (
         .ref_clk     (ref_clk),
         .arst_n      (arst_n),
         .mode        (r3[LC_MSB:LC_LSB]), // [RQ9]
         .up_seen     (up_s[c]),
         .down_seen   (down_s[c]),
         .irq_en      (loop_irq_en[c]),
         .detected    (loop_code_detected[c]),
         .remote_auto (remote_auto[c]),
         .change_req  (loop_code_change[c])
      );
   end
endmodule : liu_channel_control_regs

// [bench/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model (
   input  wire logic       ref_clk,  // clock
   input  wire logic [7:0] data_out, // read data
   input  wire logic       rdy,      // access complete
   output logic            cs_n,     // chip select
   output logic            rd_n,     // read strobe
   output logic            wr_n,     // write strobe
   output logic      [7:0] addr,     // address
   output logic      [7:0] data_in   // write data
);
   initial begin
      cs_n    = 1'b1;
      rd_n    = 1'b1;
      wr_n    = 1'b1;
      addr    = 8'hff;
      data_in = 8'h00;
   end
   // request held until rdy is sampled high; released lines show the
   // inverse so a stale value is never mistaken for a live one
   task automatic bus_op(input logic wr, input logic [7:0] a, d,
                         output logic [7:0] q, output logic ok);
      int n;
      @(posedge ref_clk);
      cs_n    <= 1'b0;
      rd_n    <= wr;
      wr_n    <= !wr;
      addr    <= a;
      data_in <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      ok = (rdy === 1'b1);
      q = data_out;
      cs_n    <= 1'b1;
      rd_n    <= 1'b1;
      wr_n    <= 1'b1;
      addr    <= ~a;
      data_in <= ~d;
      while (rdy !== 1'b0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      ok = ok && (rdy === 1'b0);
   endtask : bus_op
endmodule : host_bus_model

// [bench/liu_regs_asserts.sv]
`timescale 1ns/1ps
module liu_regs_asserts
   import liu_pkg::*;
#(
   parameter int unsigned NCH            = NUM_CHANNELS,
   parameter int unsigned PERSIST_CYCLES = LOOP_PERSIST_CYC
) (
   input wire logic                ref_clk,            // clock
   input wire logic                arst_n,             // reset
   input wire logic                cs_n,               // chip select
   input wire logic                rd_n,               // read strobe
   input wire logic                wr_n,               // write strobe
   input wire logic                data_oe_n,          // data drive
   input wire logic                rdy,                // access done
   input wire logic [NCH-1:0]      e1_mode,            // E1 select
   input wire logic [NCH-1:0]      single_rail,        // single rail
   input wire logic [NCH-1:0]      loop_up_seen,       // up code
   input wire logic [NCH-1:0]      loop_down_seen,     // down code
   input wire logic [NCH-1:0]      loop_irq_en,        // change enable
   input wire logic [NCH-1:0]      ja_in_tx,           // jitter tx
   input wire logic [NCH-1:0]      ja_in_rx,           // jitter rx
   input wire logic [NCH-1:0][7:0] ja_bw_tenths_hz,    // bandwidth
   input wire logic [NCH-1:0]      ja_fifo_64,         // deep fifo
   input wire logic [NCH-1:0]      tx_section_enable,  // tx on
   input wire logic [NCH-1:0]      tx_drive_oe_n,      // line drive
   input wire logic [NCH-1:0]      ami_coding_select,  // AMI
   input wire logic [NCH-1:0]      hdb3_b8zs_select,   // HDB3/B8ZS
   input wire logic [NCH-1:0]      loop_code_detected, // detect flag
   input wire logic [NCH-1:0]      loop_code_change    // change pulse
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_write_answered: assert property ($fell(wr_n) |-> ##[1:5] rdy)
      else $error("write strobe not answered");
   a_read_drive: assert property (!data_oe_n |->
      rdy && $past(!cs_n && !rd_n, 3))
      else $error("data driven outside a completed read");
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      a_tx_line_off: assert property (
         tx_drive_oe_n[c] == !tx_section_enable[c])
         else $error("line driver enable disagrees with tx on");
      a_ja_one_path: assert property (!(ja_in_tx[c] && ja_in_rx[c]))
         else $error("jitter attenuator in both paths");
      a_narrow_bw_deep: assert property (
         ja_bw_tenths_hz[c] == JA_BW_1P5 |-> ja_fifo_64[c])
         else $error("narrow bandwidth without deep fifo");
      a_t1_bw_fixed: assert property (
         !e1_mode[c] [*4] |-> ja_bw_tenths_hz[c] == JA_BW_3)
         else $error("T1 bandwidth not fixed");
      a_dual_rail_code: assert property (
         !single_rail[c] [*4] |->
         !(ami_coding_select[c] || hdb3_b8zs_select[c]))
         else $error("line code select outside single rail");
      a_single_rail_code: assert property (
         single_rail[c] [*4] |-> ami_coding_select[c] ^ hdb3_b8zs_select[c])
         else $error("single rail code select not exclusive");
      a_chg_on_edge: assert property (
         loop_code_change[c] |-> $changed(loop_code_detected[c]))
         else $error("change pulse without flag change");
      a_chg_when_enabled: assert property (
         $changed(loop_code_detected[c]) && loop_irq_en[c] &&
         $past(loop_irq_en[c]) |-> loop_code_change[c])
         else $error("flag change not requested");
      a_flag_cause: assert property ($rose(loop_code_detected[c]) |->
         $past(loop_up_seen[c], 3) || $past(loop_down_seen[c], 3))
         else $error("flag rose without a loop code");
   end
endmodule : liu_regs_asserts
bind liu_channel_control_regs liu_regs_asserts #(
   .NCH(NCH), .PERSIST_CYCLES(PERSIST_CYCLES)) chk_u (
   .ref_clk, .arst_n, .cs_n, .rd_n, .wr_n, .data_oe_n, .rdy,
   .e1_mode, .single_rail,
   .loop_up_seen, .loop_down_seen, .loop_irq_en, .ja_in_tx, .ja_in_rx,
   .ja_bw_tenths_hz, .ja_fifo_64, .tx_section_enable, .tx_drive_oe_n,
   .ami_coding_select, .hdb3_b8zs_select, .loop_code_detected,
   .loop_code_change);

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
   import liu_pkg::*;
;
   localparam int NC = NUM_CHANNELS;
   localparam int PC = 20; // short persistence keeps the run brief
   logic               ref_clk = 1'b0;
   logic               arst_n = 1'b0;
   logic               cs_n, rd_n, wr_n, data_oe_n, rdy;
   logic [7:0]         addr, data_in, data_out, q;
   logic [NC-1:0]      e1_mode = '0, single_rail = '0, loop_up_seen = '0;
   logic [NC-1:0]      loop_down_seen = '0, loop_irq_en = '0;
   logic [NC-1:0]      rx_section_enable, rx_term_internal, tx_term_internal;
   logic [NC-1:0]      ja_in_tx, ja_in_rx, ja_fifo_64, tx_section_enable;
   logic [NC-1:0]      tx_drive_oe_n, prbs_invert, ami_coding_select;
   logic [NC-1:0]      hdb3_b8zs_select, loop_code_detected, loop_code_change;
   logic [NC-1:0][4:0] equalizer_code;
   logic [NC-1:0][7:0] term_ohms, ja_bw_tenths_hz;
   logic [NC-1:0][2:0] tx_test_pattern_sel, loopback_mode;
   logic [7:0]         ohm [4] = '{OHM_100, OHM_110, OHM_75, OHM_120};
   logic [2:0]         lbt [4] = '{LB_DUAL, LB_ANALOG, LB_REMOTE, LB_DIGITAL};
   logic [7:0]         bw;
   int                 fail_count = 0, total_checks = 0, chg_seen = 0, base;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (loop_code_change[4] === 1'b1) chg_seen++;
   host_bus_model host_u (.ref_clk, .data_out, .rdy, .cs_n, .rd_n, .wr_n,
      .addr, .data_in);
   liu_channel_control_regs #(.PERSIST_CYCLES(PC)) dut_u (
      .ref_clk, .arst_n, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out,
      .data_oe_n, .rdy, .e1_mode, .single_rail, .loop_up_seen,
      .loop_down_seen, .loop_irq_en, .rx_section_enable, .equalizer_code,
      .rx_term_internal, .tx_term_internal, .term_ohms, .ja_in_tx,
      .ja_in_rx, .ja_bw_tenths_hz, .ja_fifo_64, .tx_section_enable,
      .tx_drive_oe_n, .tx_test_pattern_sel, .prbs_invert, .loopback_mode,
      .ami_coding_select, .hdb3_b8zs_select, .loop_code_detected,
      .loop_code_change);
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic acc(input logic w, input logic [7:0] a, d);
      logic ok;
      host_u.bus_op(w, a, d, q, ok);
      if (!ok) begin
         fail_count++;
         give_verdict();
      end
   endtask : acc
   task automatic wait_det(input logic lvl, input int lo, hi);
      int n;
      n = 0;
      while (loop_code_detected[4] !== lvl && n <= hi) begin
         @(posedge ref_clk);
         n++;
      end
      if (n > hi) begin
         fail_count++;
         give_verdict();
      end else begin
         check("detect delay", 1'b1, n >= lo);
      end
   endtask : wait_det
   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      check("oe_n reset", 8'hff, tx_drive_oe_n);
      check("reset decode", {OHM_100, JA_BW_3},
         {term_ohms[0], ja_bw_tenths_hz[0]});
      for (int i = 0; i < 64; i++) begin
         acc(1'b1, 8'(i / 4 * 16 + i % 4), 8'(i * 4 + 1));
      end
      acc(1'b1, 8'h84, 8'hff);
      acc(1'b1, 8'h14, 8'hff);
      for (int i = 0; i < 32; i++) begin
         acc(1'b0, 8'(i / 4 * 16 + i % 4), 8'h00);
         check("readback", 8'(i * 4 + 1), q);
      end
      acc(1'b0, 8'h84, 8'h00);
      check("unmapped", 8'h00, q);
      $display("test registers done");
      for (int v = 0; v < 512; v++) begin
         e1_mode[5] <= v[8];
         acc(1'b1, 8'h51, v[7:0]);
         bw = !v[8] ? JA_BW_3 : v[1] ? JA_BW_1P5 : JA_BW_10;
         check("reg1 fields",
            {v[7:6], ohm[v[5:4]], v[3:2] == 2'h1, v[3], bw,
            (v[8] & v[1]) | v[0]}, {rx_term_internal[5], tx_term_internal[5],
            term_ohms[5], ja_in_tx[5], ja_in_rx[5], ja_bw_tenths_hz[5],
            ja_fifo_64[5]});
      end
      for (int v = 0; v < 256; v++) begin
         acc(1'b1, 8'h22, v[7:0]);
         check("reg2 fields",
            {v[7:3], !v[3], v[2] ? lbt[v[1:0]] : LB_NONE},
            {prbs_invert[2], tx_test_pattern_sel[2], tx_section_enable[2],
            tx_drive_oe_n[2], loopback_mode[2]});
         acc(1'b1, 8'h70, v[7:0]);
         check("reg0 fields", v[5:0],
            {rx_section_enable[7], equalizer_code[7]});
      end
      for (int v = 0; v < 4; v++) begin
         single_rail[1] <= v[1];
         acc(1'b1, 8'h13, {2'h0, v[0], 5'h00});
         check("coding", {v[1] & v[0], v[1] & !v[0]},
            {ami_coding_select[1], hdb3_b8zs_select[1]});
      end
      $display("test field decode done");
      acc(1'b1, 8'h42, 8'h00);
      for (int m = 0; m < 3; m++) begin
         base = chg_seen;
         loop_irq_en[4] <= (m != 2);
         acc(1'b1, 8'h43, 8'(m << 6));
         loop_up_seen[4] <= (m != 1);
         loop_down_seen[4] <= (m != 2);
         repeat (PC + 10) @(posedge ref_clk);
         check("wrong code", 1'b0, loop_code_detected[4]);
         if (m > 0) begin
            loop_up_seen[4] <= (m == 1);
            loop_down_seen[4] <= (m == 2);
            wait_det(1'b1, PC, PC + 8);
            loop_up_seen[4] <= 1'b0;
            loop_down_seen[4] <= 1'b0;
            wait_det(1'b0, 1, 6);
         end
         loop_up_seen[4] <= 1'b0;
         loop_down_seen[4] <= 1'b0;
         repeat (2) @(posedge ref_clk);
         check("changes", (m == 1) ? 2 : 0, chg_seen - base);
      end
      $display("test manual detect done");
      base = chg_seen;
      loop_irq_en[4] <= 1'b1;
      acc(1'b1, 8'h43, 8'hc0);
      loop_up_seen[4] <= 1'b1;
      wait_det(1'b1, PC, PC + 8);
      loop_up_seen[4] <= 1'b0;
      @(posedge ref_clk);
      check("auto remote", LB_REMOTE, loopback_mode[4]);
      repeat (PC + 10) @(posedge ref_clk);
      check("auto hold", 1'b1, loop_code_detected[4]);
      loop_down_seen[4] <= 1'b1;
      wait_det(1'b0, PC, PC + 8);
      loop_down_seen[4] <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check("auto end", {LB_NONE, 4'h2},
         {loopback_mode[4], 4'(chg_seen - base)});
      $display("test auto detect done");
      give_verdict();
   end
endmodule : tb_top
